// >>> core/rmpi_device.sv
/*
 device end of the RMII port interface on the third switch port.
 assumes clk_sys is the 50 MHz reference seen on the reference input pin;
 the crystal path is modelled by dividing clk_sys, as the board loops it back.
*/
//////////////////////////////////////////////////////////////////////////////
// Contract
// - reduced interface only on third port
// - supports 10 and 100 Mbps rates
// - one shared 50 MHz reference clock
// - separate two-bit transmit and receive paths
// - strap high drives 50 MHz reference output; the model toggles it every clk_sys cycle, giving 25 MHz
// - board loops reference output to input
// - strap low needs external 50 MHz clock
// - straps paired 0/0 or 1/1 only
// - no receive-error output; errored frames dropped
// - PHY error line flags errored incoming frames
// - collisions inferred per standard, no pin
// - device drives valid/rxd, takes tx_en/txd
// - works against PHY or MAC partner
// - crossed pin mapping with external PHY
module rmpi_device
   import rmpi_pkg::*;
(
   // system
   input  wire logic       clk_sys,
   input  wire logic       rst_b,
   input  wire logic       clk_en,
   // straps and mode
   input  wire logic       ref_clock_out_enable_strap,
   input  wire logic       ref_frequency_select_strap,
   input  wire logic       rate_fast,
   input  wire logic       half_duplex,
   // link
   rmpi_link_if.device     link,
   // switch side, egress toward the link
   input  wire logic       sw_tx_valid,
   input  wire logic [1:0] sw_tx_dibit,
   input  wire logic       sw_tx_last,
   output logic            sw_tx_ready,
   // switch side, ingress from the link
   output logic            sw_rx_valid,
   output logic [1:0]      sw_rx_dibit,
   output logic            sw_rx_last,
   output logic            sw_rx_drop,
   // status
   output logic            collision,
   output logic            strap_bad
);
   //////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic              en_q;
      logic              sel_q;
      logic              straps_taken;
      logic              bad;
      logic              refo;
      rmpi_state_t       rx_st;
      logic [3:0]        rhold;
      logic              rx_valid;
      logic [1:0]        rx_dibit;
      logic              rx_last;
      logic              rx_drop;
      logic              crs_dv;
      logic [1:0]        rxd;
      logic [3:0]        thold;
      logic              coll;
      logic              tx_en_s1;
      logic              tx_en_s2;
      logic [1:0]        txd_s1;
      logic [1:0]        txd_s2;
      logic              tx_er_s1;
      logic              tx_er_s2;
      logic              en_s1;
      logic              en_s2;
      logic              sel_s1;
      logic              sel_s2;
      logic              fill_s1;
      logic              fill_s2;
      logic              tgap;
   } rmpi_dev_st_t;

   rmpi_dev_st_t                st;
   rmpi_dev_st_t                next_st;
   logic [3:0]                  span;
   logic                        f_valid;
   logic                        f_ready;
   logic [RMPI_FIFO_W-1:0]      f_data;
   logic                        f_pop;

   assign span = rate_fast ? RMPI_HOLD_ONE : RMPI_SLOW_HOLD;

   // egress buffer; drained one dibit per span so the switch sees back-pressure
   rmpi_fifo #(
      .WIDTH (RMPI_FIFO_W),
      .DEPTH (RMPI_FIFO_D),
      .AW    (RMPI_FIFO_AW)
   ) u_tx_fifo (
      .clk_sys   (clk_sys),
      .rst_b     (rst_b),
      .clk_en    (clk_en),
      .in_valid  (sw_tx_valid),
      .in_ready  (sw_tx_ready),
      .in_data   ({sw_tx_last, sw_tx_dibit}),
      .out_valid (f_valid),
      .out_ready (f_ready),
      .out_data  (f_data)
   );

   assign f_ready = (st.thold <= RMPI_HOLD_ONE) && !st.tgap;
   assign f_pop   = f_valid && f_ready;

   //////////////////////////////////////////////////////////////////////////
   assign link.crs_dv               = st.crs_dv;
   assign link.rxd                  = st.rxd;
   assign link.ref_clock_output_pin = st.refo;
   assign sw_rx_valid               = st.rx_valid;
   assign sw_rx_dibit               = st.rx_dibit;
   assign sw_rx_last                = st.rx_last;
   assign sw_rx_drop                = st.rx_drop;
   assign collision                 = st.coll;
   assign strap_bad                 = st.bad;

   always_comb begin
      next_st          = st;
      next_st.rx_valid = 1'b0;
      next_st.rx_last  = 1'b0;
      next_st.rx_drop  = 1'b0;
      // strap pins pass two flops; they may still settle as reset lifts
      next_st.en_s1   = ref_clock_out_enable_strap;
      next_st.en_s2   = st.en_s1;
      next_st.sel_s1  = ref_frequency_select_strap;
      next_st.sel_s2  = st.sel_s1;
      next_st.fill_s1 = 1'b1;
      next_st.fill_s2 = st.fill_s1;
      // straps caught once, when the synchroniser has filled
      if (st.fill_s2 && !st.straps_taken) begin
         next_st.straps_taken = 1'b1;
         next_st.en_q         = st.en_s2;
         next_st.sel_q        = st.sel_s2;
         next_st.bad          = (st.en_s2 != st.sel_s2);
      end
      // stand-in for the crystal-derived reference; starts on the edge that takes the strap
      next_st.refo = (next_st.en_q == RMPI_STRAP_XTAL) ? !st.refo : 1'b0;
      // link inputs synchronised (pin inputs)
      next_st.tx_en_s1 = link.tx_en;
      next_st.tx_en_s2 = st.tx_en_s1;
      next_st.txd_s1   = link.txd;
      next_st.txd_s2   = st.txd_s1;
      next_st.tx_er_s1 = link.tx_er;
      next_st.tx_er_s2 = st.tx_er_s1;
      // egress: drive valid and data, each dibit held for span cycles
      if (st.thold > RMPI_HOLD_ONE) begin
         next_st.thold = st.thold - 1'b1;
      end else if (st.tgap) begin
         // one quiet cycle after a last dibit keeps queued frames apart
         next_st.crs_dv = 1'b0;
         next_st.rxd    = RMPI_DIBIT_ZERO;
         next_st.thold  = RMPI_HOLD_ZERO;
         next_st.tgap   = 1'b0;
      end else if (f_pop) begin
         next_st.crs_dv = 1'b1;
         next_st.rxd    = f_data[RMPI_DW-1:0];
         next_st.thold  = span;
         next_st.tgap   = f_data[RMPI_DW];
      end else begin
         next_st.crs_dv = 1'b0;
         next_st.rxd    = RMPI_DIBIT_ZERO;
         next_st.thold  = RMPI_HOLD_ZERO;
      end
      // no collision pin: both directions active in half duplex
      next_st.coll = half_duplex && st.crs_dv && st.tx_en_s2;
      // ingress from partner, sampled once per span
      case (st.rx_st)
         RMPI_IDLE: begin
            if (st.tx_en_s2) begin
               next_st.rx_st    = st.tx_er_s2 ? RMPI_DROP : RMPI_DATA;
               next_st.rx_valid = !st.tx_er_s2;
               next_st.rx_drop  = st.tx_er_s2;
               next_st.rx_dibit = st.txd_s2;
               next_st.rhold    = span - 1'b1;
            end
         end
         RMPI_DATA: begin
            if (!st.tx_en_s2) begin
               next_st.rx_st   = RMPI_IDLE;
               next_st.rx_last = 1'b1;
            end else if (st.tx_er_s2) begin
               next_st.rx_st   = RMPI_DROP;
               next_st.rx_drop = 1'b1;
            end else if (st.rhold == RMPI_HOLD_ZERO) begin
               next_st.rx_valid = 1'b1;
               next_st.rx_dibit = st.txd_s2;
               next_st.rhold    = span - 1'b1;
            end else begin
               next_st.rhold = st.rhold - 1'b1;
            end
         end
         RMPI_DROP: begin
            if (!st.tx_en_s2) begin
               next_st.rx_st = RMPI_IDLE;
            end
         end
         default: begin
            next_st.rx_st = RMPI_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         st <= '0;
      end else if (clk_en) begin
         st <= next_st;
      end
   end
endmodule : rmpi_device

// >>> core/rmpi_fifo.sv
/*
 small flip-flop fifo with valid/ready on both sides.
 assumes one clock; words leave in arrival order.
*/
module rmpi_fifo #(
   parameter int WIDTH = 3,
   parameter int DEPTH = 8,
   parameter int AW    = 3
) (
   // system
   input  wire logic             clk_sys,
   input  wire logic             rst_b,
   input  wire logic             clk_en,
   // fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wp;
      logic [AW-1:0]               rp;
      logic [AW:0]                 cnt;
      logic                        room;
   } rmpi_fifo_st_t;

   rmpi_fifo_st_t st;
   rmpi_fifo_st_t next_st;
   logic          push;
   logic          pop;

   assign in_ready  = st.room;
   assign out_valid = (st.cnt != '0);
   assign out_data  = st.mem[st.rp];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb begin
      next_st = st;
      if (push) begin
         next_st.mem[st.wp] = in_data;
         next_st.wp         = st.wp + 1'b1;
      end
      if (pop) begin
         next_st.rp = st.rp + 1'b1;
      end
      next_st.cnt = st.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      // ready kept in a flop so the port above sees no count decode
      next_st.room = (next_st.cnt != DEPTH[AW:0]);
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         st <= '0;
      end else if (clk_en) begin
         st <= next_st;
      end
   end
endmodule : rmpi_fifo

// >>> core/rmpi_link_if.sv
/*
 RMII link between the switch port and its partner (PHY or MAC).
 assumes the bench supplies the shared reference clock to both ends.
*/
interface rmpi_link_if;
   logic       ref_clk;
   logic       crs_dv;
   logic [1:0] rxd;
   logic       tx_en;
   logic [1:0] txd;
   logic       tx_er;
   logic       ref_clock_output_pin;

   modport device (input ref_clk, output crs_dv, output rxd, input tx_en, input txd,
                   input tx_er, output ref_clock_output_pin);
   modport partner (input ref_clk, input crs_dv, input rxd, output tx_en, output txd,
                    output tx_er, input ref_clock_output_pin);
endinterface : rmpi_link_if

// >>> core/rmpi_partner.sv
/*
 partner end of the RMII link: an RMII MAC or PHY stand-in.
 assumes the device end shares its reference clock (clk_sys).
*/
module rmpi_partner
   import rmpi_pkg::*;
(
   // system
   input  wire logic       clk_sys,
   input  wire logic       rst_b,
   input  wire logic       clk_en,
   // link
   rmpi_link_if.partner    link,
   // user transmit
   input  wire logic       usr_fast,
   input  wire logic       usr_tx_valid,
   input  wire logic [1:0] usr_tx_dibit,
   input  wire logic       usr_tx_last,
   input  wire logic       usr_tx_err,
   output logic            usr_tx_ready,
   // user receive
   output logic            usr_rx_valid,
   output logic [1:0]      usr_rx_dibit,
   output logic            usr_rx_active
);
   typedef struct packed {
      logic       tx_en;
      logic [1:0] txd;
      logic       tx_er;
      logic [3:0] hold;
      logic       stop;
      logic       rdy;
      logic       rx_valid;
      logic [1:0] rx_dibit;
      logic       rx_active;
      logic [3:0] rhold;
   } rmpi_prt_st_t;

   rmpi_prt_st_t st;
   rmpi_prt_st_t next_st;
   logic [3:0]   span;

   assign span          = usr_fast ? RMPI_HOLD_ONE : RMPI_SLOW_HOLD;
   assign link.tx_en    = st.tx_en;
   assign link.txd      = st.txd;
   assign link.tx_er    = st.tx_er;
   assign usr_tx_ready  = st.rdy;
   assign usr_rx_valid  = st.rx_valid;
   assign usr_rx_dibit  = st.rx_dibit;
   assign usr_rx_active = st.rx_active;

   always_comb begin
      next_st          = st;
      next_st.rx_valid = 1'b0;
      // transmit: each dibit held for span cycles; ready high means the next edge takes
      if (st.hold > RMPI_HOLD_ONE) begin
         next_st.hold = st.hold - 1'b1;
      end else if (st.stop) begin
         next_st.tx_en = 1'b0;
         next_st.tx_er = 1'b0;
         next_st.txd   = RMPI_DIBIT_ZERO;
         next_st.stop  = 1'b0;
         next_st.hold  = RMPI_HOLD_ZERO;
      end else if (usr_tx_valid && st.rdy) begin
         next_st.tx_en = 1'b1;
         next_st.txd   = usr_tx_dibit;
         next_st.tx_er = usr_tx_err;
         next_st.stop  = usr_tx_last;
         next_st.hold  = span;
      end else begin
         next_st.tx_en = 1'b0;
         next_st.tx_er = 1'b0;
         next_st.hold  = RMPI_HOLD_ZERO;
      end
      // registered ready: an acknowledge after the take would gap every fast frame
      next_st.rdy = (next_st.hold <= RMPI_HOLD_ONE) && !next_st.stop;
      // receive: sample once per span while the device drives valid
      next_st.rx_active = link.crs_dv;
      if (!link.crs_dv) begin
         next_st.rhold = RMPI_HOLD_ZERO;
      end else if (st.rhold == RMPI_HOLD_ZERO) begin
         next_st.rx_valid = 1'b1;
         next_st.rx_dibit = link.rxd;
         next_st.rhold    = span - 1'b1;
      end else begin
         next_st.rhold = st.rhold - 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         st <= '0;
      end else if (clk_en) begin
         st <= next_st;
      end
   end
endmodule : rmpi_partner

// >>> core/rmpi_pkg.sv
/*
 RMII port interface shared definitions: rates, strap codes, frame states, fifo shape.
 assumes a single 50 MHz system clock that is also the RMII reference clock.
*/
package rmpi_pkg;
   localparam int          RMPI_CLK_MHZ       = 50;
   localparam int          RMPI_REF_MHZ       = 50;
   localparam int          RMPI_XTAL_MHZ      = 25;
   localparam int          RMPI_RATE_FAST     = 100;
   localparam int          RMPI_RATE_SLOW     = 10;
   localparam int          RMPI_SLOW_HOLD_INT = RMPI_RATE_FAST / RMPI_RATE_SLOW;
   localparam logic [3:0]  RMPI_SLOW_HOLD     = RMPI_SLOW_HOLD_INT[3:0];
   localparam logic [3:0]  RMPI_HOLD_ZERO     = 4'h0;
   localparam logic [3:0]  RMPI_HOLD_ONE      = 4'h1;
   localparam int          RMPI_DW            = 2;
   localparam int          RMPI_FIFO_W        = 3;
   localparam int          RMPI_FIFO_D        = 8;
   localparam int          RMPI_FIFO_AW       = 3;
   localparam logic        RMPI_STRAP_EXT     = 1'b0;
   localparam logic        RMPI_STRAP_XTAL    = 1'b1;
   localparam logic [1:0]  RMPI_DIBIT_ZERO    = 2'h0;

   typedef enum logic [1:0] {
      RMPI_IDLE = 2'b00,
      RMPI_DATA = 2'b01,
      RMPI_DROP = 2'b10
   } rmpi_state_t;
endpackage : rmpi_pkg

// >>> dv/rmpi_link_monitor.sv
/*
 link checker for the RMII port pair: clock output, dibit spans, error line.
 assumes it watches the interface joining device and partner ends.
*/
module rmpi_link_monitor
   import rmpi_pkg::*;
(
   // clock and mode
   input  wire logic       ref_clk,
   input  wire logic       rst_b,
   input  wire logic       rate_fast,
   input  wire logic       usr_fast,
   input  wire logic       ref_clock_out_enable_strap,
   // link
   input  wire logic       crs_dv,
   input  wire logic [1:0] rxd,
   input  wire logic       tx_en,
   input  wire logic [1:0] txd,
   input  wire logic       tx_er,
   input  wire logic       ref_clock_output_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!rst_b);
   //////////////////////////////////////////////////////////////////////////////
   // run length of the dibit now on each path; repeated values only give multiples
   logic [1:0] p_rxd, p_txd;
   logic       p_crs, p_ten;
   int         rx_run, tx_run;
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         {p_rxd, p_txd, p_crs, p_ten} <= '0;
         rx_run <= 1;
         tx_run <= 1;
      end else begin
         {p_rxd, p_txd, p_crs, p_ten} <= {rxd, txd, crs_dv, tx_en};
         rx_run <= (crs_dv && p_crs && rxd == p_rxd) ? rx_run + 1 : 1;
         tx_run <= (tx_en && p_ten && txd == p_txd) ? tx_run + 1 : 1;
      end
   end
   //////////////////////////////////////////////////////////////////////////////
   a_ref_off: assert property (!ref_clock_out_enable_strap |-> !ref_clock_output_pin)
      else $error("reference output active with strap low");
   a_ref_toggle: assert property (ref_clock_output_pin |=> !ref_clock_output_pin)
      else $error("reference output high two cycles");
   a_ref_runs: assert property ((ref_clock_out_enable_strap && !ref_clock_output_pin)
      |-> ##[1:3] ref_clock_output_pin)
      else $error("reference output stuck low");
   a_rx_slow_hold: assert property ((!rate_fast && crs_dv && p_crs && rxd != p_rxd)
      |-> rx_run % RMPI_SLOW_HOLD_INT == 0)
      else $error("receive dibit span not ten cycles");
   a_tx_slow_hold: assert property ((!usr_fast && tx_en && p_ten && txd != p_txd)
      |-> tx_run % RMPI_SLOW_HOLD_INT == 0)
      else $error("transmit dibit span not ten cycles");
   a_rx_frame_span: assert property ((!rate_fast && $rose(crs_dv)) |=> crs_dv [*8])
      else $error("slow receive frame shorter than one span");
   a_tx_frame_span: assert property ((!usr_fast && $rose(tx_en)) |=> tx_en [*8])
      else $error("slow transmit frame shorter than one span");
   a_err_framed: assert property (tx_er |-> tx_en)
      else $error("error line raised outside a frame");
endmodule // rmpi_link_monitor

// >>> dv/rmpi_test.sv
/*
 self-checking bench: device and partner ends joined back to back.
 assumes clk_sys serves as the shared link reference clock.
*/
module rmpi_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk_sys = 1'b0, rst_b = 1'b0, strap_en = 1'b1, strap_sel = 1'b1;
   logic       rate_fast = 1'b0, half_duplex = 1'b0, usr_fast = 1'b0, ref_prev = 1'b0;
   logic       crs_prev = 1'b0;
   logic       sw_tx_valid = 1'b0, sw_tx_last = 1'b0, usr_tx_valid = 1'b0;
   logic       usr_tx_last = 1'b0, usr_tx_err = 1'b0;
   logic [1:0] sw_tx_dibit = 2'h0, usr_tx_dibit = 2'h0, sw_rx_dibit, usr_rx_dibit;
   logic       sw_tx_ready, sw_rx_valid, sw_rx_last, sw_rx_drop, collision, strap_bad;
   logic       usr_tx_ready, usr_rx_valid, usr_rx_active;
   logic [1:0] exp_par[$], exp_dev[$];
   int         n_mismatch = 0, num_checks = 0, cyc = 0, n_last = 0, n_drop = 0;
   int         n_late = 0, n_coll = 0, n_tog = 0, refused = 0;
   bit         err_frame = 1'b0, dropped = 1'b0;
   integer     seed = 32'hA5E5;
   rmpi_link_if lk();
   assign lk.ref_clk = clk_sys;
   always #10 clk_sys = ~clk_sys;
   //////////////////////////////////////////////////////////////////////////////
   rmpi_device rmpi_device_i (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(1'b1),
      .ref_clock_out_enable_strap(strap_en), .ref_frequency_select_strap(strap_sel),
      .rate_fast(rate_fast), .half_duplex(half_duplex), .link(lk), .sw_tx_valid(sw_tx_valid),
      .sw_tx_dibit(sw_tx_dibit), .sw_tx_last(sw_tx_last), .sw_tx_ready(sw_tx_ready),
      .sw_rx_valid(sw_rx_valid), .sw_rx_dibit(sw_rx_dibit), .sw_rx_last(sw_rx_last),
      .sw_rx_drop(sw_rx_drop), .collision(collision), .strap_bad(strap_bad));
   rmpi_partner rmpi_partner_i (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(1'b1), .link(lk),
      .usr_fast(usr_fast), .usr_tx_valid(usr_tx_valid), .usr_tx_dibit(usr_tx_dibit),
      .usr_tx_last(usr_tx_last), .usr_tx_err(usr_tx_err), .usr_tx_ready(usr_tx_ready),
      .usr_rx_valid(usr_rx_valid), .usr_rx_dibit(usr_rx_dibit), .usr_rx_active(usr_rx_active));
   rmpi_link_monitor rmpi_link_monitor_i (.ref_clk(lk.ref_clk), .rst_b(rst_b),
      .rate_fast(rate_fast), .usr_fast(usr_fast), .ref_clock_out_enable_strap(strap_en),
      .crs_dv(lk.crs_dv), .rxd(lk.rxd), .tx_en(lk.tx_en), .txd(lk.txd), .tx_er(lk.tx_er),
      .ref_clock_output_pin(lk.ref_clock_output_pin));
   //////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic dev_send(input int n);
      for (int i = 0; i < n; i++) begin
         sw_tx_valid = 1'b1;
         sw_tx_dibit = 2'($random(seed));
         sw_tx_last = (i == n - 1);
         exp_par.push_back(sw_tx_dibit);
         for (int w = 0; w < 300 && sw_tx_ready !== 1'b1; w++) begin
            refused++;
            @(negedge clk_sys);
         end
         @(negedge clk_sys);
      end
      sw_tx_valid = 1'b0;
      sw_tx_last = 1'b0;
   endtask
   // err_at below zero sends a clean frame
   task automatic par_send(input int n, input int err_at);
      for (int i = 0; i < n; i++) begin
         usr_tx_valid = 1'b1;
         usr_tx_dibit = 2'($random(seed));
         usr_tx_last = (i == n - 1);
         usr_tx_err = (i == err_at);
         if (err_at < 0)
            exp_dev.push_back(usr_tx_dibit);
         for (int w = 0; w < 300 && usr_tx_ready !== 1'b1; w++)
            @(negedge clk_sys);
         @(negedge clk_sys);
      end
      usr_tx_valid = 1'b0;
      usr_tx_last = 1'b0;
      usr_tx_err = 1'b0;
   endtask
   // frame end reaches the switch side three cycles after the link goes quiet
   task automatic drain;
      for (int w = 0; w < 600 && (exp_par.size() || exp_dev.size() || lk.tx_en || lk.crs_dv);
           w++)
         @(negedge clk_sys);
      repeat (4) @(negedge clk_sys);
   endtask
   //////////////////////////////////////////////////////////////////////////////
   // one-cycle pulses are caught mid-cycle, where they are settled
   always @(negedge clk_sys) begin
      if (usr_rx_valid === 1'b1)
         check("partner dibit", usr_rx_dibit, exp_par.size() ? exp_par.pop_front() : 2'bxx);
      if (sw_rx_drop === 1'b1) begin
         n_drop++;
         dropped = 1'b1;
      end
      if (sw_rx_valid === 1'b1 && dropped)
         n_late++;
      else if (sw_rx_valid === 1'b1 && !err_frame)
         check("device dibit", sw_rx_dibit, exp_dev.size() ? exp_dev.pop_front() : 2'bxx);
      n_last += (sw_rx_last === 1'b1);
      n_coll += (collision === 1'b1);
      n_tog += (lk.ref_clock_output_pin !== ref_prev);
      ref_prev = lk.ref_clock_output_pin;
      check("partner carrier", usr_rx_active, crs_prev);
      crs_prev = lk.crs_dv;
   end
   // whole run needs well under a thousand cycles; over forty times that means a hang
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 40000) begin
         n_mismatch++;
         complete_run();
      end
   end
   initial begin
      repeat (5) @(negedge clk_sys);
      rst_b = 1'b1;
      @(negedge clk_sys);
      // slow half duplex first, then fast full duplex; both directions at once
      for (int r = 0; r < 2; r++) begin
         rate_fast = r[0];
         usr_fast = r[0];
         half_duplex = !r[0];
         n_coll = 0;
         refused = 0;
         fork
            dev_send(20);
            par_send(4 + ($random(seed) & 15), -1);
         join
         drain();
         check("tx refused", refused > 0, !r[0]);
         check("collision seen", n_coll > 0, !r[0]);
         check("frame ends", n_last, r + 1);
         check("queues left", exp_par.size() + exp_dev.size(), 0);
      end
      err_frame = 1'b1;
      par_send(12, 5);
      drain();
      err_frame = 1'b0;
      check("drop pulses", n_drop, 1);
      check("valids after drop", n_late, 0);
      dropped = 1'b0;
      par_send(6, -1);
      drain();
      check("queues after drop", exp_dev.size(), 0);
      for (int s = 0; s < 4; s++) begin
         rst_b = 1'b0;
         strap_en = s[1];
         strap_sel = s[0];
         @(negedge clk_sys);
         rst_b = 1'b1;
         repeat (3) @(negedge clk_sys);
         n_tog = 0;
         repeat (16) @(negedge clk_sys);
         check("strap fault", strap_bad, s[1] ^ s[0]);
         check("ref out runs", n_tog > 0, s[1]);
      end
      complete_run();
   end
endmodule // rmpi_test
